// ==== include/esc_cfg.svh ====
// register offsets, field positions and reset values of the enhanced mode block
`ifndef ESC_CFG_SVH
`define ESC_CFG_SVH
// ====================
// register offsets
`define ESC_A_RXST     16'h0000
`define ESC_A_TXST     16'h0001
`define ESC_A_PACE0    16'h0002
`define ESC_A_CMD      16'h0006
`define ESC_A_MDATA    16'h0007
`define ESC_A_MWIN     16'h0008
`define ESC_A_UCFG     16'h0009
`define ESC_A_PCFG     16'h000a
`define ESC_A_PERIOD   16'h000b
`define ESC_A_CHEN     16'h000c
`define ESC_A_RCT      16'h000d
`define ESC_A_ISTAT    16'h000e
`define ESC_A_IMASK    16'h000f
`define ESC_A_RES      16'h0010
`define ESC_A_MEM0     16'h0020
`define ESC_A_RSVD     16'h3cb8
// ====================
// field positions
`define ESC_B_RX_EN    3
`define ESC_B_RX_MCF   2
`define ESC_B_TX_EN    3
`define ESC_B_TX_EC    5
`define ESC_B_TX_SNC   4
`define ESC_B_TX_MULTI_PHY_SELECT  0
`define ESC_B_PL_OVM   15
`define ESC_B_PL_LAST  13
`define ESC_B_PL_EQ    11
`define ESC_B_PL_EN    10
`define ESC_B_PL_DIS   9
`define ESC_B_PL_MULTI_PHY_SELECT  7
`define ESC_B_CMD_FLG  0
`define ESC_B_RCT_NO_CHECK_OR_CONGESTION 5
`define ESC_B_U_ACT    0
`define ESC_B_U_SPLIT  1
`define ESC_B_U_MIIMIX 2
`define ESC_B_U_SATM   3
`define ESC_B_U_RUN    4
`define ESC_B_P_LVL    0
`define ESC_OP2_MEMWR  3'h1
`define ESC_AAL0       2'h0
`define ESC_AAL5       2'h1
`define ESC_NLVL       4
`define ESC_NMEM       8
`define ESC_RST_PERIOD 16'h0010
`define ESC_RST_PL     16'h0000
`endif

// ==== include/esc_pkg.sv ====
// types shared by the enhanced mode configuration block
package esc_pkg;
	typedef enum logic [2:0] {
		ESC_OP_NORMAL = 3'h0,
		ESC_OP_PM_ON  = 3'h1,
		ESC_OP_PM_OFF = 3'h2,
		ESC_OP_EXT    = 3'h7
	} esc_op_e;
	typedef struct packed {
		logic       rst;
		logic [2:0] atm_command_field;
		logic [7:0] channel_number;
		logic [2:0] secondary_opcode;
		logic       flag;
	} esc_cmd_s;
	typedef struct packed {
		logic serial_channel_four_lost;
		logic dma_channel_one_lost;
		logic dma_events_to_utopia;
		logic address_filter_reject_lost;
		logic parallel_iface_port_lost;
		logic pccard_a_lost;
		logic fast_ethernet_lost;
		logic two_wire_overlap;
		logic sync_serial_overlap;
		logic mgmt_overlap;
		logic mode_mismatch;
		logic dma_two_bad_mode;
	} esc_res_s;
	typedef enum logic [1:0] {
		ESC_IDLE,
		ESC_EXEC
	} esc_state_e;
endpackage

// ==== src/esc_mode_cfg.sv ====
// enhanced segmentation mode configuration, command and resource sharing logic
//
// The register addresses and the plain strobed port were decided locally.
`include "esc_cfg.svh"
// Function
// - running memory changes only through write command
// - channels and pace period change while operating
// - serial ATM areas overlap companion peripheral areas
// - UTOPIA takes DMA one and channel four
// - UTOPIA removes reject inputs and port handshakes
// - split bus removes PC-card and MII pins
// - unused PHY address lines release their pins
// - secondary opcode honoured only for opcode 111
// - per-level mask gates table overrun events
// - final level flag stops lower level scheduling
// - disabled level skipped, lower levels still serviced
// - check bit meaning follows adaptation type
module esc_mode_cfg (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic [15:0]           addr,
	input  wire logic [15:0]           wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output logic      [15:0]           rdata,
	output logic                       irq,
	input  wire logic [3:0]            pace_overrun_pin,
	input  wire logic                  utopia_event_pin,
	output logic                       pace_tick,
	output logic      [3:0]            level_service,
	output logic                       ptp_service,
	output logic                       skip_crc,
	output logic                       congestion,
	output logic      [3:0]            pm_active,
	output logic      [3:0]            channel_active,
	output logic      [4:0]            phy_addr_oe,
	output logic      [4:0]            phy_alt_func,
	output esc_pkg::esc_res_s          resources
);
	// ====================
	// pin synchronisers
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic [4:0] sync3_q;
	logic [4:0] sync_d;
	always_comb begin
		sync_d = {utopia_event_pin, pace_overrun_pin};
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
			sync3_q <= 5'h00;
		end else begin
			sync1_q <= sync_d;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end
	logic [3:0] ovr_rise;
	logic       uto_rise;
	assign ovr_rise = sync2_q[3:0] & ~sync3_q[3:0];
	assign uto_rise = sync2_q[4] & ~sync3_q[4];

	// ====================
	// register file
	logic [15:0]       rx_function_status_q, rx_function_status_d;
	logic [15:0]       tx_function_status_q, tx_function_status_d;
	logic [15:0]       pace_q [`ESC_NLVL];
	logic [15:0]       pace_d [`ESC_NLVL];
	esc_pkg::esc_cmd_s cmd_q, cmd_d;
	logic [15:0]       mdata_q, mdata_d;
	logic [15:0]       mem_q [`ESC_NMEM];
	logic [15:0]       mem_d [`ESC_NMEM];
	logic [15:0]       ucfg_q, ucfg_d;
	logic [15:0]       pcfg_q, pcfg_d;
	logic [15:0]       period_q, period_d;
	logic [15:0]       pcnt_q, pcnt_d;
	logic [3:0]        chen_q, chen_d;
	logic [15:0]       rct_q, rct_d;
	logic [7:0]        istat_q, istat_d;
	logic [7:0]        imask_q, imask_d;
	logic [3:0]        pm_q, pm_d;
	logic [15:0]       rdata_q, rdata_d;
	logic              tick_q, tick_d;
	esc_pkg::esc_state_e st_q, st_d;

	// register write, command and event decode
	logic       running;
	logic [7:0] ev;
	logic       illegal_wr;
	logic       done_ev;
	logic [15:0] rd_mux;
	logic [3:0] ovr_ev;
	esc_pkg::esc_op_e op;
	assign running = ucfg_q[`ESC_B_U_RUN];
	assign op      = esc_pkg::esc_op_e'(cmd_q.atm_command_field);

	// overrun events pass only for levels whose mask bit allows them
	generate
		for (genvar g = 0; g < `ESC_NLVL; g++) begin : g_ovr
			assign ovr_ev[g] = ovr_rise[g] & ~pace_q[g][`ESC_B_PL_OVM];
		end
	endgenerate

	always_comb begin
		rx_function_status_d = rx_function_status_q;
		tx_function_status_d = tx_function_status_q;
		pace_d   = pace_q;
		cmd_d    = cmd_q;
		mdata_d  = mdata_q;
		mem_d    = mem_q;
		ucfg_d   = ucfg_q;
		pcfg_d   = pcfg_q;
		period_d = period_q;
		chen_d   = chen_q;
		rct_d    = rct_q;
		imask_d  = imask_q;
		pm_d     = pm_q;
		st_d     = st_q;
		illegal_wr = 1'b0;
		done_ev  = 1'b0;
		// writes accepted at any time except to the memory window while running, channel set and period included
		if (wr) begin
			case (addr)
				`ESC_A_RXST:   rx_function_status_d = wdata;
				`ESC_A_TXST:   tx_function_status_d = wdata;
				`ESC_A_CMD:    cmd_d = wdata;
				`ESC_A_MDATA:  mdata_d = wdata;
				`ESC_A_UCFG:   ucfg_d = wdata;
				`ESC_A_PCFG:   pcfg_d = wdata;
				`ESC_A_PERIOD: period_d = wdata;
				`ESC_A_CHEN:   chen_d = wdata[3:0];
				`ESC_A_RCT:    rct_d = wdata;
				`ESC_A_IMASK:  imask_d = wdata[7:0];
				`ESC_A_MWIN:   begin
					// direct change of memory while running is refused
					if (running)
						illegal_wr = 1'b1;
					else
						mem_d[mdata_q[2:0]] = wdata;
				end
				default: begin
					if (addr >= `ESC_A_PACE0 && addr < `ESC_A_PACE0 + 16'h0004)
						pace_d[addr[1:0] - 2'h2] = wdata;
				end
			endcase
		end
		// command execution one cycle after the flag is written
		case (st_q)
			esc_pkg::ESC_IDLE: begin
				if (cmd_q.flag)
					st_d = esc_pkg::ESC_EXEC;
			end
			esc_pkg::ESC_EXEC: begin
				case (op)
					esc_pkg::ESC_OP_PM_ON:  pm_d[cmd_q.channel_number[1:0]] = 1'b1;
					esc_pkg::ESC_OP_PM_OFF: pm_d[cmd_q.channel_number[1:0]] = 1'b0;
					esc_pkg::ESC_OP_EXT: begin
						// secondary opcode only looked at here
						if (cmd_q.secondary_opcode == `ESC_OP2_MEMWR)
							mem_d[cmd_q.channel_number[2:0]] = mdata_q;
					end
					default: ;
				endcase
				cmd_d.flag = 1'b0;
				done_ev = 1'b1;
				st_d = esc_pkg::ESC_IDLE;
			end
			default: st_d = esc_pkg::ESC_IDLE;
		endcase
	end

	// ====================
	// event status, read clears and set wins
	always_comb begin
		ev = {2'h0, uto_rise, illegal_wr, done_ev, |ovr_ev, 2'h0};
		ev[0] = resources.mode_mismatch;
		ev[1] = resources.dma_two_bad_mode;
		istat_d = istat_q;
		if (rd && addr == `ESC_A_ISTAT)
			istat_d = 8'h00;
		istat_d = istat_d | ev;
	end

	// ====================
	// pace period counter, period may change on the fly
	always_comb begin
		tick_d = 1'b0;
		pcnt_d = pcnt_q + 16'h0001;
		if (pcnt_q >= period_q) begin
			pcnt_d = 16'h0000;
			tick_d = 1'b1;
		end
	end

	// ====================
	// read mux, data stand the cycle after the strobe
	always_comb begin
		rd_mux = 16'h0000;
		case (addr)
			`ESC_A_RXST:   rd_mux = rx_function_status_q;
			`ESC_A_TXST:   rd_mux = tx_function_status_q;
			`ESC_A_CMD:    rd_mux = cmd_q;
			`ESC_A_MDATA:  rd_mux = mdata_q;
			`ESC_A_MWIN:   rd_mux = mem_q[mdata_q[2:0]];
			`ESC_A_UCFG:   rd_mux = ucfg_q;
			`ESC_A_PCFG:   rd_mux = pcfg_q;
			`ESC_A_PERIOD: rd_mux = period_q;
			`ESC_A_CHEN:   rd_mux = {12'h000, chen_q};
			`ESC_A_RCT:    rd_mux = rct_q;
			`ESC_A_ISTAT:  rd_mux = {8'h00, istat_q};
			`ESC_A_IMASK:  rd_mux = {8'h00, imask_q};
			`ESC_A_RES:    rd_mux = {4'h0, resources};
			`ESC_A_RSVD:   rd_mux = 16'h0000;
			default: begin
				if (addr >= `ESC_A_PACE0 && addr < `ESC_A_PACE0 + 16'h0004)
					rd_mux = pace_q[addr[1:0] - 2'h2];
				else if (addr >= `ESC_A_MEM0 && addr < `ESC_A_MEM0 + 16'h0008)
					rd_mux = mem_q[addr[2:0]];
			end
		endcase
		rdata_d = rd ? rd_mux : 16'h0000;
	end

	// ====================
	// all registers of the block except the pin synchronisers
	always_ff @(posedge mclk) begin
		if (reset) begin
			rx_function_status_q <= 16'h0000;
			tx_function_status_q <= 16'h0000;
			for (int i = 0; i < `ESC_NLVL; i++)
				pace_q[i] <= `ESC_RST_PL;
			for (int i = 0; i < `ESC_NMEM; i++)
				mem_q[i] <= 16'h0000;
			cmd_q    <= '0;
			mdata_q  <= 16'h0000;
			ucfg_q   <= 16'h0000;
			pcfg_q   <= 16'h0000;
			period_q <= `ESC_RST_PERIOD;
			pcnt_q   <= 16'h0000;
			chen_q   <= 4'h0;
			rct_q    <= 16'h0000;
			istat_q  <= 8'h00;
			imask_q  <= 8'h00;
			pm_q     <= 4'h0;
			rdata_q  <= 16'h0000;
			tick_q   <= 1'b0;
			st_q     <= esc_pkg::ESC_IDLE;
		end else begin
			rx_function_status_q <= rx_function_status_d;
			tx_function_status_q <= tx_function_status_d;
			pace_q   <= pace_d;
			mem_q    <= mem_d;
			cmd_q    <= cmd_d;
			mdata_q  <= mdata_d;
			ucfg_q   <= ucfg_d;
			pcfg_q   <= pcfg_d;
			period_q <= period_d;
			pcnt_q   <= pcnt_d;
			chen_q   <= chen_d;
			rct_q    <= rct_d;
			istat_q  <= istat_d;
			imask_q  <= imask_d;
			pm_q     <= pm_d;
			rdata_q  <= rdata_d;
			tick_q   <= tick_d;
			st_q     <= st_d;
		end
	end

	// ====================
	// level scheduling: stop below the final level, skip disabled ones
	logic [3:0] last_seen;
	generate
		for (genvar g = 0; g < `ESC_NLVL; g++) begin : g_lvl
			if (g == 0) begin : g_first
				assign last_seen[g] = 1'b0;
			end else begin : g_rest
				assign last_seen[g] = last_seen[g-1] | pace_q[g-1][`ESC_B_PL_LAST];
			end
			assign level_service[g] = tick_q & ~last_seen[g] &
				~pace_q[g][`ESC_B_PL_DIS];
		end
	endgenerate
	assign ptp_service = tick_q;

	// ====================
	// receive connection entry, check bit read by adaptation type
	assign skip_crc   = rct_q[`ESC_B_RCT_NO_CHECK_OR_CONGESTION] & (rct_q[1:0] == `ESC_AAL0);
	assign congestion = rct_q[`ESC_B_RCT_NO_CHECK_OR_CONGESTION] & (rct_q[1:0] == `ESC_AAL5);

	// ====================
	// resource sharing flags and pin ownership
	logic uact;
	logic satm;
	logic all_en;
	logic any_en;
	assign uact   = ucfg_q[`ESC_B_U_ACT];
	assign satm   = ucfg_q[`ESC_B_U_SATM];
	assign all_en = rx_function_status_q[`ESC_B_RX_EN] & tx_function_status_q[`ESC_B_TX_EN] &
		pace_q[0][`ESC_B_PL_EN];
	assign any_en = rx_function_status_q[`ESC_B_RX_EN] | tx_function_status_q[`ESC_B_TX_EN] |
		pace_q[0][`ESC_B_PL_EN];
	always_comb begin
		resources = '0;
		resources.serial_channel_four_lost   = uact;
		resources.dma_channel_one_lost       = uact;
		resources.dma_events_to_utopia       = uact;
		resources.address_filter_reject_lost = uact;
		resources.parallel_iface_port_lost   = uact | satm;
		resources.pccard_a_lost      = uact & (ucfg_q[`ESC_B_U_SPLIT] |
			~ucfg_q[`ESC_B_U_MIIMIX]);
		resources.fast_ethernet_lost = uact & (ucfg_q[`ESC_B_U_SPLIT] |
			ucfg_q[`ESC_B_U_MIIMIX]);
		resources.two_wire_overlap    = satm;
		resources.sync_serial_overlap = satm;
		resources.mgmt_overlap        = satm | uact;
		resources.mode_mismatch       = any_en & ~all_en;
		resources.dma_two_bad_mode    = (uact | satm) & ~pcfg_q[`ESC_B_P_LVL];
	end

	// phy address lines drive only when the UTOPIA port uses them
	assign phy_addr_oe  = uact ? ucfg_q[12:8] : 5'h00;
	assign phy_alt_func = ~phy_addr_oe;

	// ====================
	// outputs
	assign rdata          = rdata_q;
	assign irq            = |(istat_q & imask_q);
	assign pace_tick      = tick_q;
	assign pm_active      = pm_q;
	assign channel_active = chen_q;
endmodule // esc_mode_cfg

// ==== testbench/esc_mode_cfg_chk.sv ====
// assertion checker for the enhanced mode configuration block
module esc_mode_cfg_chk (
	input wire logic              mclk,
	input wire logic              reset,
	input wire logic [15:0]       addr,
	input wire logic [15:0]       wdata,
	input wire logic              wr,
	input wire logic              rd,
	input wire logic              irq,
	input wire logic              pace_tick,
	input wire logic [3:0]        level_service,
	input wire logic              ptp_service,
	input wire logic              skip_crc,
	input wire logic              congestion,
	input wire logic [3:0]        pm_active,
	input wire logic [4:0]        phy_addr_oe,
	input wire logic [4:0]        phy_alt_func,
	input wire esc_pkg::esc_res_s resources
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cmd_q, cmd_d;
	logic [1:0] clr_q, clr_d;
	logic       utp;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// ====================
	// history of command writes and status or mask accesses
	always_comb begin
		cmd_d = {cmd_q[1:0], wr && addr == 16'h0006};
		clr_d = {clr_q[0], (wr || rd) && addr[15:1] == 15'h0007};
	end
	always_ff @(posedge mclk) begin
		cmd_q <= cmd_d;
		clr_q <= clr_d;
	end
	assign utp = resources.serial_channel_four_lost;
	// flagged command write for channel zero with a given opcode
	sequence s_pm(logic [2:0] op);
		wr && addr == 16'h0006 && wdata[14:12] == op && wdata[11:4] == 8'h00 && wdata[0];
	endsequence
	// ====================
	// assertions
	a_pm_on: assert property (s_pm(3'h1) |-> ##[2:3] pm_active[0])
		else $error("monitoring not switched on");
	a_pm_off: assert property (s_pm(3'h2) |-> ##[2:3] !pm_active[0])
		else $error("monitoring not switched off");
	a_pm_cause: assert property ($changed(pm_active) |-> |cmd_q)
		else $error("monitoring changed without command");
	a_alt_release: assert property (phy_alt_func == ~phy_addr_oe)
		else $error("phy pin not released");
	a_oe_needs_utopia: assert property (|phy_addr_oe |-> utp)
		else $error("phy address driven without utopia");
	a_utopia_takes: assert property (resources.dma_channel_one_lost == utp
		&& resources.dma_events_to_utopia == utp)
		else $error("dma channel sharing wrong");
	a_utopia_pins: assert property (resources.address_filter_reject_lost == utp
		&& resources.parallel_iface_port_lost == (utp || resources.two_wire_overlap))
		else $error("reject or port handshake sharing wrong");
	a_split_loss: assert property (resources.pccard_a_lost || resources.fast_ethernet_lost
		|-> utp)
		else $error("pins lost without utopia");
	a_ptp_kept: assert property (ptp_service == pace_tick)
		else $error("port queue not serviced on tick");
	a_level_tick: assert property (|level_service |-> pace_tick)
		else $error("level serviced off tick");
	a_check_bit: assert property (!(skip_crc && congestion))
		else $error("check bit read two ways");
	a_irq_clear: assert property ($fell(irq) |-> |clr_q)
		else $error("interrupt dropped without access");
endmodule // esc_mode_cfg_chk
bind esc_mode_cfg esc_mode_cfg_chk i_esc_mode_cfg_chk (.*);

// ==== testbench/esc_phy_model.sv ====
// model of the phy side event lines
module esc_phy_model (
	input  wire logic       mclk,
	output logic      [3:0] pace_overrun_pin,
	output logic            utopia_event_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// lines idle low between events
	initial begin
		pace_overrun_pin = 4'h0;
		utopia_event_pin = 1'b0;
	end
	// raise the chosen lines long enough for the synchroniser
	task automatic pulse(input logic [4:0] m);
		@(posedge mclk);
		{utopia_event_pin, pace_overrun_pin} <= m;
		repeat (4) @(posedge mclk);
		{utopia_event_pin, pace_overrun_pin} <= 5'h00;
	endtask
endmodule // esc_phy_model

// ==== testbench/esc_mode_cfg_test.sv ====
// self-checking testbench of the enhanced mode configuration block
module esc_mode_cfg_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic              mclk, reset, wr, rd, irq, pace_tick, ptp_service, skip_crc, congestion;
	logic       [15:0] addr, wdata, rdata;
	logic       [3:0]  pace_overrun_pin, level_service, pm_active, channel_active;
	logic              utopia_event_pin;
	logic       [4:0]  phy_addr_oe, phy_alt_func;
	esc_pkg::esc_res_s resources;
	int                failures = 0, n_checks = 0, n;
	logic       [15:0] uc[4] = '{16'h0008, 16'h0303, 16'h0305, 16'h0301};
	logic       [9:0]  ex[4] = '{10'h027, 10'h3f9, 10'h3e9, 10'h3f1};
	logic       [4:0]  oe[4] = '{5'h00, 5'h03, 5'h03, 5'h03};
	esc_mode_cfg i_esc_mode_cfg (.*);
	esc_phy_model i_esc_phy_model (.*);
	// ====================
	// clock and watchdog
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#100us;
		failures++;
		test_done;
	end
	// ====================
	// bus and compare tasks
	task automatic chk(input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [15:0] a, e, m);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask
	task automatic do_cmd(input logic [2:0] op, input logic [7:0] ch, input logic [2:0] sec);
		wr_reg(16'h0006, {1'b0, op, ch, sec, 1'b1});
		repeat (4) @(posedge mclk);
	endtask
	task automatic wait_tick(output int k);
		k = 0;
		do begin
			@(posedge mclk);
			#1;
			k++;
		end while (pace_tick !== 1'b1 && k < 100);
	endtask
	// ====================
	// scenarios
	task automatic t_reset;
		rd_chk(16'h000b, 16'h0010, 16'hffff);
		rd_chk(16'h0000, 16'h0000, 16'hffff);
		// software clears the whole memory page before any operation
		for (int i = 0; i < 8; i++) begin
			wr_reg(16'h0007, 16'(i));
			wr_reg(16'h0008, 16'h0000);
			rd_chk(16'h0020 + 16'(i), 16'h0000, 16'hffff);
		end
		wr_reg(16'h3cb8, 16'h0000);
		rd_chk(16'h3cb8, 16'h0000, 16'hffff);
		wr_reg(16'h0011, 16'hffff);
		rd_chk(16'h0011, 16'h0000, 16'hffff);
	endtask
	task automatic t_mode;
		wr_reg(16'h000f, 16'h0001);
		wr_reg(16'h0000, 16'h0008);
		@(posedge mclk);
		#1;
		chk({15'h0, irq}, 16'h0001);
		wr_reg(16'h0001, 16'h0008);
		wr_reg(16'h0002, 16'h0400);
		rd_chk(16'h000e, 16'h0001, 16'h0001);
		rd_chk(16'h000e, 16'h0000, 16'h0001);
		chk({15'h0, irq}, 16'h0000);
	endtask
	task automatic t_cmd;
		wr_reg(16'h0007, 16'h5a5a);
		do_cmd(3'h1, 8'h00, 3'h0);
		chk({12'h0, pm_active}, 16'h0001);
		rd_chk(16'h000e, 16'h0008, 16'h0008);
		do_cmd(3'h0, 8'h04, 3'h1);
		rd_chk(16'h0024, 16'h0000, 16'hffff);
		do_cmd(3'h7, 8'h05, 3'h2);
		rd_chk(16'h0025, 16'h0000, 16'hffff);
		do_cmd(3'h7, 8'h03, 3'h1);
		rd_chk(16'h0023, 16'h5a5a, 16'hffff);
		do_cmd(3'h2, 8'h00, 3'h0);
		chk({12'h0, pm_active}, 16'h0000);
	endtask
	task automatic t_run;
		wr_reg(16'h000f, 16'h0010);
		wr_reg(16'h0009, 16'h0010);
		wr_reg(16'h0008, 16'h1234);
		rd_chk(16'h0022, 16'h0000, 16'hffff);
		chk({15'h0, irq}, 16'h0001);
		rd_chk(16'h000e, 16'h0010, 16'h0010);
		chk({15'h0, irq}, 16'h0000);
		do_cmd(3'h7, 8'h02, 3'h1);
		rd_chk(16'h0022, 16'h5a5a, 16'hffff);
		wr_reg(16'h0009, 16'h0000);
	endtask
	task automatic t_share;
		wr_reg(16'h000a, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			wr_reg(16'h0009, uc[i]);
			chk({6'h0, resources[11:2]}, {6'h0, ex[i]});
			chk({11'h0, phy_addr_oe}, {11'h0, oe[i]});
			chk({11'h0, phy_alt_func}, {11'h0, ~oe[i]});
		end
		// utopia active without level request mode is flagged
		wr_reg(16'h000a, 16'h0000);
		chk({15'h0, resources.dma_two_bad_mode}, 16'h0001);
		wr_reg(16'h000a, 16'h0001);
		wr_reg(16'h000f, 16'h0020);
		i_esc_phy_model.pulse(5'h10);
		repeat (6) @(posedge mclk);
		rd_chk(16'h000e, 16'h0020, 16'h0020);
		wr_reg(16'h0009, 16'h0000);
	endtask
	task automatic t_pace;
		wr_reg(16'h0003, 16'h0200);
		wr_reg(16'h0004, 16'h2000);
		wr_reg(16'h000c, 16'h0005);
		chk({12'h0, channel_active}, 16'h0005);
		wr_reg(16'h000b, 16'h0020);
		wait_tick(n);
		wait_tick(n);
		chk(16'(n), 16'h0021);
		chk({12'h0, level_service}, 16'h0005);
		chk({15'h0, ptp_service}, 16'h0001);
		wr_reg(16'h000f, 16'h0004);
		wr_reg(16'h0002, 16'h8400);
		rd_chk(16'h000e, 16'h0000, 16'h0004);
		i_esc_phy_model.pulse(5'h01);
		repeat (6) @(posedge mclk);
		rd_chk(16'h000e, 16'h0000, 16'h0004);
		wr_reg(16'h0002, 16'h0400);
		i_esc_phy_model.pulse(5'h01);
		repeat (6) @(posedge mclk);
		rd_chk(16'h000e, 16'h0004, 16'h0004);
	endtask
	task automatic t_rct;
		wr_reg(16'h000d, 16'h0020);
		chk({14'h0, skip_crc, congestion}, 16'h0002);
		wr_reg(16'h000d, 16'h0021);
		chk({14'h0, skip_crc, congestion}, 16'h0001);
		wr_reg(16'h000d, 16'h0001);
		chk({14'h0, skip_crc, congestion}, 16'h0000);
	endtask
	// ====================
	// verdict and main sequence
	task automatic test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		addr = 16'h0000;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		t_reset;
		t_mode;
		t_cmd;
		t_run;
		t_share;
		t_pace;
		t_rct;
		test_done;
	end
endmodule // esc_mode_cfg_test
